// ===== acl_link.sv
`timescale 1ns/1ps
`include "acl_params.svh"
// Contract
// [RULE1] names ending in _n are active low, codec reset included
// [RULE2] drive the codec reset output to all attached codecs
// [RULE3] emit frame sync at a fixed 48 kHz frame rate
// [RULE4] frame sync also carries the stream number of the frame; code does so in high-definition mode only
// [RULE5] legacy mode: codec makes the 12.288 MHz bit clock, pin is input
// [RULE6] high-definition mode: device drives a 24 MHz bit clock out
// [RULE7] keep the bit clock pin pulled low at all times; code releases the pull-down while rst_n is low
// [RULE8] drive serial out; high-definition mode changes data on both edges
// [RULE9] three serial inputs, sampled on one edge only
// [RULE10] at power-good rise, sync and serial out both high select x4
// [RULE11] without strap pull-ups lanes default to four x1 links
// [RULE12] strap value holds until the next power-good rising edge; code clears it to x1 while power_good is low
module acl_link (
   input  wire logic                         sys_clk,
   input  wire logic                         rst_n,
   input  wire logic                         link_bit_clock_i,
   input  wire logic                         audio_pll_clk,
   input  wire logic                         power_good,
   input  wire logic                         link_en,
   input  wire logic                         hd_mode,
   input  wire logic [`ACL_SID_W-1:0]        stream_id,
   input  wire logic [`ACL_WORD_W-1:0]       tx_data,
   input  wire logic                         tx_valid,
   output logic                              tx_ready,
   output logic [`ACL_RX_LINES-1:0][`ACL_WORD_W-1:0] rx_data,
   output logic                              rx_valid,
   output logic                              codec_reset_n,
   input  wire logic                         frame_sync_i,
   output logic                              frame_sync_o,
   output logic                              frame_sync_oe_n,
   input  wire logic                         serial_out_i,
   output logic                              serial_out_o,
   output logic                              serial_out_oe_n,
   output logic                              link_bit_clock_o,
   output logic                              link_bit_clock_oe_n,
   output logic                              link_bit_clock_pd,
   input  wire logic [`ACL_RX_LINES-1:0]     serial_in,
   output logic                              lane_x4
);
   logic                  pg_s1_q;
   logic                  pg_s2_q;
   logic                  pg_s3_q;
   logic                  fs_s1_q;
   logic                  fs_s2_q;
   logic                  so_s1_q;
   logic                  so_s2_q;
   logic                  pg_rise;
   logic                  lane_x4_q;
   logic                  run_q;
   logic                  hd_q;
   logic                  codec_reset_n_q;
   logic                  oe_n_q;
   logic                  pd_q;
   logic                  bclk_en_q;
   acl_pkg::acl_word_t    f_data;
   logic                  f_valid;
   logic                  pop_rdy;
   logic                  req_q;
   logic                  ack_s1_q;
   logic                  ack_s2_q;
   acl_pkg::acl_word_t    hold_q;
   acl_pkg::acl_sid_t     sid_hold_q;
   logic                  rxt_s1_q;
   logic                  rxt_s2_q;
   logic                  rxt_s3_q;
   logic [`ACL_RX_LINES-1:0][`ACL_WORD_W-1:0] rx_data_q;
   logic                  rx_valid_q;
   logic                  lr_s1_q;
   logic                  lr_s2_q;
   logic                  lh_s1_q;
   logic                  lh_s2_q;
   logic                  lq_s1_q;
   logic                  lq_s2_q;
   logic [`ACL_CNT_W-1:0] cnt_q;
   acl_pkg::acl_phase_t   phase_q;
   logic                  sync_q;
   acl_pkg::acl_word_t    shift_q;
   acl_pkg::acl_sid_t     sid_q;
   logic                  ack_q;
   logic                  lo_q;
   logic                  p_q;
   logic                  n_q;
   logic [`ACL_RX_LINES-1:0][`ACL_WORD_W-1:0] rx_sh_q;
   logic [`ACL_RX_LINES-1:0][`ACL_WORD_W-1:0] rx_hold_q;
   logic                  rx_tog_q;
   logic [`ACL_CNT_W-1:0] flen_m1;
   logic [`ACL_CNT_W-1:0] tag_end;
   logic [`ACL_CNT_W-1:0] slot_end;
   logic                  frame_end;
   logic                  in_sid;
   logic [1:0]            sid_idx;
   logic                  rx_win;
   logic                  rx_last;
   logic                  hi_bit;
   logic                  lo_bit;
   logic                  pl_s1_q;
   logic                  pl_s2_q;
   logic                  bclk_q;
   logic                  bclk_oe_n_q;
   always_ff @(posedge sys_clk) begin
      pg_s1_q <= power_good;
      pg_s2_q <= pg_s1_q;
      pg_s3_q <= pg_s2_q;
      fs_s1_q <= frame_sync_i;
      fs_s2_q <= fs_s1_q;
      so_s1_q <= serial_out_i;
      so_s2_q <= so_s1_q;
   end
   assign pg_rise = pg_s2_q && !pg_s3_q;
   // [RULE12] power_good is the strap reset, so rst_n leaves the strap alone
   always_ff @(posedge sys_clk) begin
      if (!pg_s2_q) begin
         lane_x4_q <= 1'h0;
      // [RULE10] [RULE11] strap sample
      end else if (pg_rise) begin
         lane_x4_q <= fs_s2_q && so_s2_q;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         run_q <= 1'h0;
         hd_q  <= 1'h0;
      end else begin
         // pins stay released through the strap sample
         run_q <= pg_s2_q && pg_s3_q && link_en;
         hd_q  <= run_q ? hd_q : hd_mode;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         codec_reset_n_q <= 1'h0;
         oe_n_q          <= 1'h1;
         pd_q            <= 1'h0;
         bclk_en_q       <= 1'h0;
      end else begin
         // [RULE1] [RULE2] active-low codec reset
         codec_reset_n_q <= run_q;
         oe_n_q          <= !run_q;
         // [RULE7] pull-down kept on
         pd_q            <= 1'h1;
         bclk_en_q       <= run_q && hd_q;
      end
   end
   acl_fifo #(
      .W     (`ACL_WORD_W),
      .DEPTH (`ACL_FIFO_DEPTH)
   ) u_fifo (
      .clk       (sys_clk),
      .rst_n     (rst_n),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (pop_rdy)
   );
   // one word per frame drains, so the fifo really fills
   assign pop_rdy = run_q && (req_q == ack_s2_q);
   always_ff @(posedge sys_clk) begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      if (!rst_n || !run_q) begin
         req_q <= 1'h0;
      end else if (f_valid && pop_rdy) begin
         req_q <= !req_q;
      end
   end
   // held stable while the link side owns the handshake
   always_ff @(posedge sys_clk) begin
      if (f_valid && pop_rdy) begin
         hold_q     <= f_data;
         sid_hold_q <= stream_id;
      end
   end
   always_ff @(posedge sys_clk) begin
      rxt_s1_q <= rx_tog_q;
      rxt_s2_q <= rxt_s1_q;
      rxt_s3_q <= rxt_s2_q;
      if (!rst_n) begin
         rx_valid_q <= 1'h0;
         rx_data_q  <= '0;
      end else begin
         rx_valid_q <= rxt_s2_q != rxt_s3_q;
         if (rxt_s2_q != rxt_s3_q) begin
            rx_data_q <= rx_hold_q;
         end
      end
   end
   assign lane_x4         = lane_x4_q;
   assign codec_reset_n   = codec_reset_n_q;
   assign frame_sync_oe_n = oe_n_q;
   assign serial_out_oe_n = oe_n_q;
   assign link_bit_clock_pd = pd_q;
   assign rx_data         = rx_data_q;
   assign rx_valid        = rx_valid_q;
   // [RULE6] divide-by-two of the audio pll
   always_ff @(posedge audio_pll_clk) begin
      pl_s1_q     <= bclk_en_q;
      pl_s2_q     <= pl_s1_q;
      bclk_q      <= pl_s2_q ? !bclk_q : 1'h0;
      bclk_oe_n_q <= !pl_s2_q;
   end
   assign link_bit_clock_o    = bclk_q;
   assign link_bit_clock_oe_n = bclk_oe_n_q;
   // [RULE5] legacy clock comes back in from the codec
   always_ff @(posedge link_bit_clock_i) begin
      lr_s1_q <= run_q;
      lr_s2_q <= lr_s1_q;
      lh_s1_q <= hd_q;
      lh_s2_q <= lh_s1_q;
      lq_s1_q <= req_q;
      lq_s2_q <= lq_s1_q;
   end
   assign flen_m1 = lh_s2_q ? `ACL_CNT_W'(`ACL_HD_FRAME_BITS - 1)
                            : `ACL_CNT_W'(`ACL_LEG_FRAME_BITS - 1);
   assign tag_end = lh_s2_q ? `ACL_CNT_W'(`ACL_HD_TAG_BITS - 1)
                            : `ACL_CNT_W'(`ACL_SLOT_POS - 1);
   assign slot_end = lh_s2_q ? `ACL_CNT_W'(`ACL_SLOT_POS + `ACL_HD_SLOT_CYC - 1)
                             : `ACL_CNT_W'(`ACL_RX_END);
   assign frame_end = cnt_q == flen_m1;
   assign in_sid  = cnt_q >= `ACL_CNT_W'(`ACL_SID_POS) &&
                    cnt_q < `ACL_CNT_W'(`ACL_SID_POS + `ACL_SID_W);
   assign sid_idx = 2'(`ACL_SID_POS + `ACL_SID_W - 1 - cnt_q);
   assign rx_win  = cnt_q >= `ACL_CNT_W'(`ACL_SLOT_POS) &&
                    cnt_q <= `ACL_CNT_W'(`ACL_RX_END);
   assign rx_last = cnt_q == `ACL_CNT_W'(`ACL_RX_END);
   // [RULE3] frame counter
   always_ff @(posedge link_bit_clock_i) begin
      if (!lr_s2_q) begin
         cnt_q   <= '0;
         phase_q <= acl_pkg::ACL_PH_TAG;
      end else begin
         cnt_q <= frame_end ? '0 : cnt_q + 1'h1;
         unique case (phase_q)
            acl_pkg::ACL_PH_TAG: begin
               if (cnt_q == `ACL_CNT_W'(`ACL_SLOT_POS - 1)) begin
                  phase_q <= acl_pkg::ACL_PH_SLOT;
               end else if (cnt_q == tag_end) begin
                  phase_q <= acl_pkg::ACL_PH_SID;
               end
            end
            acl_pkg::ACL_PH_SID: begin
               if (cnt_q == `ACL_CNT_W'(`ACL_SLOT_POS - 1)) begin
                  phase_q <= acl_pkg::ACL_PH_SLOT;
               end
            end
            acl_pkg::ACL_PH_SLOT: begin
               if (cnt_q == slot_end) begin
                  phase_q <= acl_pkg::ACL_PH_REST;
               end
            end
            acl_pkg::ACL_PH_REST: begin
               if (frame_end) begin
                  phase_q <= acl_pkg::ACL_PH_TAG;
               end
            end
         endcase
      end
   end
   // [RULE3] [RULE4] sync marker and stream number
   always_ff @(posedge link_bit_clock_i) begin
      if (!lr_s2_q) begin
         sync_q <= 1'h0;
      end else begin
         unique case (phase_q)
            acl_pkg::ACL_PH_TAG: sync_q <= 1'h1;
            acl_pkg::ACL_PH_SID: sync_q <= lh_s2_q ? (in_sid && sid_q[sid_idx]) : 1'h1;
            acl_pkg::ACL_PH_SLOT: sync_q <= 1'h0;
            acl_pkg::ACL_PH_REST: sync_q <= 1'h0;
         endcase
      end
   end
   assign frame_sync_o = sync_q;
   // a word is taken only at a frame boundary
   always_ff @(posedge link_bit_clock_i) begin
      if (!lr_s2_q) begin
         ack_q   <= 1'h0;
         shift_q <= '0;
         sid_q   <= '0;
      end else if (frame_end) begin
         ack_q   <= lq_s2_q;
         shift_q <= (lq_s2_q != ack_q) ? hold_q : '0;
         sid_q   <= (lq_s2_q != ack_q) ? sid_hold_q : sid_q;
      end else if (phase_q == acl_pkg::ACL_PH_SLOT) begin
         // [RULE8] two bits per clock in hd
         shift_q <= lh_s2_q ? {shift_q[`ACL_WORD_W-3:0], 2'h0}
                            : {shift_q[`ACL_WORD_W-2:0], 1'h0};
      end
   end
   assign hi_bit = phase_q == acl_pkg::ACL_PH_SLOT && shift_q[`ACL_WORD_W-1];
   assign lo_bit = phase_q == acl_pkg::ACL_PH_SLOT &&
                   (lh_s2_q ? shift_q[`ACL_WORD_W-2] : shift_q[`ACL_WORD_W-1]);
   // [RULE8] xor pair gives a glitch-free double-pumped output
   always_ff @(posedge link_bit_clock_i) begin
      if (!lr_s2_q) begin
         p_q  <= 1'h0;
         lo_q <= 1'h0;
      end else begin
         p_q  <= hi_bit ^ n_q;
         lo_q <= lo_bit;
      end
   end
   always_ff @(negedge link_bit_clock_i) begin
      n_q <= lr_s2_q ? (lo_q ^ p_q) : 1'h0;
   end
   assign serial_out_o = p_q ^ n_q;
   // [RULE9] single-edge capture per line
   for (genvar g = 0; g < `ACL_RX_LINES; g++) begin : g_rx
      always_ff @(posedge link_bit_clock_i) begin
         if (!lr_s2_q) begin
            rx_sh_q[g] <= '0;
         end else if (rx_win) begin
            rx_sh_q[g] <= {rx_sh_q[g][`ACL_WORD_W-2:0], serial_in[g]};
         end
      end
      always_ff @(posedge link_bit_clock_i) begin
         if (rx_last) begin
            rx_hold_q[g] <= {rx_sh_q[g][`ACL_WORD_W-2:0], serial_in[g]};
         end
      end
   end
   always_ff @(posedge link_bit_clock_i) begin
      if (!lr_s2_q) begin
         rx_tog_q <= 1'h0;
      end else if (rx_last) begin
         rx_tog_q <= !rx_tog_q;
      end
   end
   reset_level_a: assert property (@(posedge sys_clk) // [RULE1]
      !rst_n |=> !codec_reset_n_q)
      else $error("codec reset not asserted low in reset");
   codec_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
      !pg_s2_q |-> ##2 !codec_reset_n_q)
      else $error("codec reset released without power good");
   strap_x4_a: assert property (@(posedge sys_clk) // [RULE10]
      pg_rise && fs_s2_q && so_s2_q && oe_n_q |=> lane_x4_q)
      else $error("x4 strap not latched");
   strap_x1_a: assert property (@(posedge sys_clk) // [RULE11]
      pg_rise && !(fs_s2_q && so_s2_q) |=> !lane_x4_q)
      else $error("x1 default not taken");
   strap_hold_a: assert property (@(posedge sys_clk) // [RULE12]
      pg_s2_q && pg_s3_q ##1 pg_s2_q |-> $stable(lane_x4_q))
      else $error("strap changed without power good rise");
   pull_down_a: assert property (@(posedge sys_clk) // [RULE7]
      rst_n |=> link_bit_clock_pd)
      else $error("bit clock pull-down dropped");
   hd_clock_a: assert property (@(posedge audio_pll_clk) disable iff (!pl_s2_q) // [RULE6]
      pl_s2_q ##1 pl_s2_q |-> bclk_q != $past(bclk_q) && !bclk_oe_n_q)
      else $error("hd bit clock not toggling");
   frame_wrap_a: assert property (@(posedge link_bit_clock_i) // [RULE3]
      disable iff (!lr_s2_q)
      frame_end ##1 lr_s2_q |-> cnt_q == '0 ##1 sync_q)
      else $error("frame length or sync start wrong");
   stream_num_a: assert property (@(posedge link_bit_clock_i) // [RULE4]
      disable iff (!lr_s2_q)
      lh_s2_q && cnt_q == `ACL_CNT_W'(`ACL_SID_POS) |=> sync_q == sid_q[`ACL_SID_W-1])
      else $error("stream number bit wrong on sync");
   ddr_shift_a: assert property (@(posedge link_bit_clock_i) // [RULE8]
      disable iff (!lr_s2_q)
      phase_q == acl_pkg::ACL_PH_SLOT && lh_s2_q && !frame_end |=>
      shift_q == {$past(shift_q[`ACL_WORD_W-3:0]), 2'h0})
      else $error("hd slot not shifting two bits");
   rx_capture_a: assert property (@(posedge link_bit_clock_i) // [RULE9]
      disable iff (!lr_s2_q)
      rx_last |=> rx_tog_q != $past(rx_tog_q) && rx_hold_q[0][0] == $past(serial_in[0]))
      else $error("rx word not captured at slot end");
endmodule

// ===== acl_params.svh
`ifndef ACL_PARAMS_SVH
`define ACL_PARAMS_SVH
`define ACL_FRAME_HZ      48000
`define ACL_LEG_BCLK_HZ   12288000
`define ACL_HD_BCLK_HZ    24000000
`define ACL_PLL_HZ        48000000
`define ACL_LEG_FRAME_BITS (`ACL_LEG_BCLK_HZ / `ACL_FRAME_HZ)
`define ACL_HD_FRAME_BITS  (`ACL_HD_BCLK_HZ / `ACL_FRAME_HZ)
`define ACL_CNT_W         9
`define ACL_HD_TAG_BITS   4
`define ACL_SID_POS       8
`define ACL_SID_W         4
`define ACL_SLOT_POS      16
`define ACL_WORD_W        32
`define ACL_HD_SLOT_CYC   (`ACL_WORD_W / 2)
`define ACL_RX_END        (`ACL_SLOT_POS + `ACL_WORD_W - 1)
`define ACL_FIFO_DEPTH    8
`define ACL_RX_LINES      3
`endif

// ===== acl_pkg.sv
`include "acl_params.svh"
package acl_pkg;
   typedef enum logic [1:0] {
      ACL_PH_TAG  = 2'h0,
      ACL_PH_SID  = 2'h1,
      ACL_PH_SLOT = 2'h2,
      ACL_PH_REST = 2'h3
   } acl_phase_t;
   typedef logic [`ACL_WORD_W-1:0] acl_word_t;
   typedef logic [`ACL_SID_W-1:0]  acl_sid_t;
endpackage

// ===== acl_fifo.sv
`timescale 1ns/1ps
module acl_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = cnt_q != (AW+1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers wrap only because DEPTH is a power of two
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= push ? wr_q + 1'h1 : wr_q;
         rd_q  <= pop ? rd_q + 1'h1 : rd_q;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ===== acl_codec_model.sv
`timescale 1ns/1ps
module acl_codec_model #(
   parameter logic [95:0] PAT = 96'h0
) (
   input  wire logic        codec_reset_n,
   input  wire logic        gen_clk,
   input  wire logic        clk_pin,
   input  wire logic        fs_pin,
   input  wire logic        so_pin,
   output logic             bclk,
   output logic [2:0]       sdi,
   output logic [31:0]      tx_word,
   output int               frames,
   output logic [3:0]       sid,
   output int               hi_chg,
   output int               lo_chg
);
   logic [9:0]  cur = 10'h3FF;
   logic        fs_q = 1'b0;
   logic [31:0] sh = 32'h0;
   initial begin
      bclk = 1'b0;
      sdi = 3'h0;
      tx_word = 32'h0;
      frames = 0;
      sid = 4'h0;
      hi_chg = 0;
      lo_chg = 0;
   end
   always #32 bclk = gen_clk ? ~bclk : 1'b0;
   always @(posedge clk_pin) begin
      fs_q <= fs_pin;
      // codec held while its reset is low
      if (!codec_reset_n) cur <= 10'h3FF;
      else if (fs_pin && !fs_q && cur >= 10'd64) cur <= 10'd3;
      else if (cur != 10'h3FF) cur <= cur + 10'h1;
      if (cur >= 10'd10 && cur <= 10'd13) sid <= {sid[2:0], fs_pin};
   end
   // lines change on the falling edge; idle lines keep toggling
   always @(negedge clk_pin) begin
      for (int g = 0; g < 3; g++) begin
         // cur runs one ahead of the link's bit count
         sdi[g] <= (cur >= 10'd17 && cur <= 10'd48) ? PAT[32*g + 48 - cur] : ~sdi[g];
      end
      if (cur >= 10'd18 && cur <= 10'd49) sh <= {sh[30:0], so_pin};
      if (cur == 10'd50) begin
         tx_word <= sh;
         frames <= frames + 1;
      end
   end
   // which clock phase each data change falls in
   always @(so_pin) begin
      if (clk_pin) hi_chg++;
      else lo_chg++;
   end
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
   localparam realtime     DLY = 2.0;
   localparam logic [95:0] PAT = 96'hFEDC_0BA9_1234_5678_8421_F00D;
   localparam int          LIMIT = 30000;
   logic             sys_clk = 1'b0;
   logic             pll_clk = 1'b0;
   logic             rst_n = 1'b0;
   logic             power_good = 1'b0;
   logic             link_en = 1'b0;
   logic             hd_mode = 1'b0;
   logic [3:0]       stream_id = 4'h0;
   logic [31:0]      tx_data = 32'h0;
   logic             tx_valid = 1'b0;
   logic [1:0]       pu = 2'h0;
   logic             tx_ready, rx_valid, codec_reset_n, lane_x4, codec_bclk;
   logic [2:0][31:0] rx_data;
   logic             fs_o, fs_oe_n, so_o, so_oe_n, bc_o, bc_oe_n, bc_pd;
   logic [2:0]       sdi;
   logic [31:0]      tx_word;
   logic [3:0]       sid;
   int               frames, hi_chg, lo_chg;
   int               errors = 0;
   int               compares = 0;
   int               cyc = 0;
   wire              fs_pin, so_pin, bc_pin;
   initial forever #25 sys_clk = ~sys_clk;
   initial forever #10.4167 pll_clk = ~pll_clk;
   // strap pull-ups when fitted, else the pins sit low
   assign fs_pin = !fs_oe_n ? fs_o : pu[1];
   assign so_pin = !so_oe_n ? so_o : pu[0];
   // undriven bit clock follows the pull-down in hd mode, the codec clock in legacy mode
   assign bc_pin = !bc_oe_n ? bc_o : (!hd_mode ? codec_bclk : !bc_pd);
   acl_link u_acl_link (
      .sys_clk(sys_clk), .rst_n(rst_n), .link_bit_clock_i(bc_pin), .audio_pll_clk(pll_clk),
      .power_good(power_good), .link_en(link_en), .hd_mode(hd_mode), .stream_id(stream_id),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .codec_reset_n(codec_reset_n), .frame_sync_i(fs_pin),
      .frame_sync_o(fs_o), .frame_sync_oe_n(fs_oe_n), .serial_out_i(so_pin),
      .serial_out_o(so_o), .serial_out_oe_n(so_oe_n), .link_bit_clock_o(bc_o),
      .link_bit_clock_oe_n(bc_oe_n), .link_bit_clock_pd(bc_pd), .serial_in(sdi),
      .lane_x4(lane_x4));
   acl_codec_model #(.PAT(PAT)) u_acl_codec_model (
      .codec_reset_n(codec_reset_n), .gen_clk(!hd_mode), .clk_pin(bc_pin), .fs_pin(fs_pin),
      .so_pin(so_pin), .bclk(codec_bclk), .sdi(sdi), .tx_word(tx_word), .frames(frames),
      .sid(sid), .hi_chg(hi_chg), .lo_chg(lo_chg));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(posedge sys_clk);
      #DLY;
   endtask
   // frame length, measured at a fixed point of the codec's frame
   task automatic period(output realtime p);
      realtime t0;
      @(frames);
      t0 = $realtime;
      @(frames);
      p = $realtime - t0;
      #1;
   endtask
   task automatic rx_chk();
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         cyc_n(1);
         while (rx_valid !== 1'b1 && n < 2000) begin
            cyc_n(1);
            n++;
         end
      end
      for (int g = 0; g < 3; g++) chk(rx_data[g], PAT[32*g +: 32]);
   endtask
   task automatic t_reset();
      cyc_n(4);
      chk(codec_reset_n, 1'b0);
      chk({fs_oe_n, so_oe_n, bc_oe_n}, 3'h7);
      rst_n = 1'b1;
      cyc_n(2);
      chk(bc_pd, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_strap(input logic [1:0] pu_v, input logic exp);
      link_en = 1'b0;
      power_good = 1'b0;
      pu = pu_v;
      cyc_n(6);
      chk(lane_x4, 1'b0);
      power_good = 1'b1;
      cyc_n(6);
      chk(lane_x4, exp);
      $display("test strap %b done", pu_v);
   endtask
   task automatic t_legacy();
      int          n, k;
      logic        rdy;
      realtime     p;
      logic [31:0] q[$];
      hd_mode = 1'b0;
      link_en = 1'b1;
      n = 0;
      while (codec_reset_n !== 1'b1 && n < 20) begin
         cyc_n(1);
         n++;
      end
      chk(codec_reset_n, 1'b1);
      chk(bc_oe_n, 1'b1);
      period(p);
      chk(p > 16383.0 && p < 16385.0, 1'b1);
      rx_chk();
      // fill until refused while the link drains one word a frame
      n = 0;
      rdy = 1'b1;
      tx_data = 32'h5A00_0000;
      tx_valid = 1'b1;
      while (rdy && n < 20) begin
         rdy = tx_ready;
         cyc_n(1);
         if (rdy) begin
            n++;
            tx_data = 32'h5A00_0000 + n;
         end
      end
      tx_valid = 1'b0;
      chk(n >= 8 && n <= 9, 1'b1);
      chk(tx_ready, 1'b0);
      k = 0;
      while (q.size() < n && k < 40) begin
         @(frames);
         #1;
         k++;
         if (tx_word !== 32'h0) q.push_back(tx_word);
      end
      for (int i = 0; i < n; i++) chk(q[i], 32'h5A00_0000 + i);
      chk(tx_ready, 1'b1);
      chk(lane_x4, 1'b1);
      $display("test legacy done");
   endtask
   task automatic t_hd();
      int      h, l;
      realtime p;
      link_en = 1'b0;
      cyc_n(20);
      hd_mode = 1'b1;
      stream_id = 4'hA;
      link_en = 1'b1;
      cyc_n(20);
      chk(bc_oe_n, 1'b0);
      period(p);
      chk(p > 20831.0 && p < 20836.0, 1'b1);
      cyc_n(1);
      tx_data = 32'hAAAA_AAAA;
      tx_valid = 1'b1;
      cyc_n(3);
      tx_valid = 1'b0;
      h = hi_chg;
      l = lo_chg;
      period(p);
      period(p);
      chk(hi_chg - h >= 16 && lo_chg - l >= 16, 1'b1);
      // stream number only changes when a queued word is sent
      chk(sid, 4'hA);
      rx_chk();
      chk(lane_x4, 1'b1);
      $display("test hd done");
   endtask
   task automatic summarize();
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // hang guard, well above the few hundred microseconds expected
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         errors++;
         summarize();
      end
   end
   initial begin
      t_reset();
      t_strap(2'b00, 1'b0);
      t_strap(2'b01, 1'b0);
      t_strap(2'b11, 1'b1);
      t_legacy();
      t_hd();
      summarize();
   end
endmodule
